// ==== hw/bpvd_bridge_decode.sv ====
// The Avalon-MM register port was left to the implementer.
`timescale 1ns/1ps
// Operation
// - Prefetch memory reads in window, except VGA-mode frame buffer reads
// - Claim primary memory hits, pass downstream
// - Ignore secondary memory hits in window
// - Outside window: primary ignored, secondary upstream
// - 64-bit compare, SAC upper bits zero
// - SAC downstream only if upper base zero
// - Base 24h, limit 26h, low nibble 1h
// - Base low bits zeros, limit ones
// - Reset window is bottom 1MB block
// - Window off when 64-bit base exceeds limit
// - VGA mode forwards frame buffer and I/O
// - VGA mode ignores secondary VGA accesses
// - Frame buffer A0000h through BFFFFh
// - Frame buffer reads single phase, BEs kept
// - VGA I/O ranges, 1KB alias, high zero
// - VGA BIOS region not decoded
// - Snoop claims palette writes, forwards downstream
// - VGA plus snoop equals VGA only
// - Memory writes are posted
// - I/O, config writes retried and delayed; config writes are never claimed here
// - All reads retried and delayed; config reads are never claimed here
// - Delayed write response stored, returned
// - Memory enable downstream, master enable upstream
module bpvd_bridge_decode (
    input  wire logic                ref_clk,
    input  wire logic                reset_n,
    input  wire logic [3:0]          avs_address,
    input  wire logic                avs_read,
    input  wire logic                avs_write,
    input  wire logic [31:0]         avs_writedata,
    input  wire logic [3:0]          avs_byteenable,
    output logic [31:0]              avs_readdata,
    output logic                     avs_waitrequest,
    output logic [1:0]               avs_response,
    input  wire bpvd_pkg::bpvd_req_t req_in,
    input  wire logic                tgt_done,
    input  wire logic [1:0]          tgt_resp,
    output bpvd_pkg::bpvd_dec_t      dec_out,
    output logic                     dly_wr_resp_valid,
    output logic [1:0]               dly_wr_resp
);
    import bpvd_pkg::*;

    logic        rst_s1_ff;
    logic        rst_s2_ff;
    logic [15:0] cmd_ff;
    logic [11:0] pf_base_ff;
    logic [11:0] pf_limit_ff;
    logic [31:0] pf_base_hi_ff;
    logic [31:0] pf_limit_hi_ff;
    logic [15:0] brctl_ff;
    logic        ack_ff;
    logic        wait_ff;
    logic [31:0] rdata_ff;
    logic [1:0]  resp_ff;
    bpvd_dec_t   dec_ff;
    bpvd_dly_st_t dly_st_ff;
    logic [1:0]  dly_resp_ff;
    logic        dly_vld_ff;
    logic [7:0]  hit_cnt_ff;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_s1_ff <= 1'b0;
            rst_s2_ff <= 1'b0;
        end else begin
            rst_s1_ff <= 1'b1;
            rst_s2_ff <= rst_s1_ff;
        end
    end

    // Avalon slave: one wait cycle, then acknowledge
    logic acc;
    logic [31:0] wmask;
    logic [31:0] rd_mux;
    assign acc = (avs_read | avs_write) & ~ack_ff;
    assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                    {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [31:0] m);
        merge = (old & ~m) | (nw & m);
    endfunction : merge

    logic [31:0] nxt_pf;
    assign nxt_pf = merge({pf_limit_ff, PF_LOW_NIBBLE,
                           pf_base_ff, PF_LOW_NIBBLE},
                          avs_writedata, wmask);

    // Writes land at the edge that sees waitrequest low
    always_ff @(posedge ref_clk or negedge rst_s2_ff) begin
        if (!rst_s2_ff) begin
            cmd_ff   <= 16'h0000;
            brctl_ff <= 16'h0000;
        end else if (avs_write && ack_ff) begin
            case (avs_address)
                REG_CMD_ADDR: begin
                    cmd_ff <= 16'(merge({16'h0000, cmd_ff},
                                        avs_writedata, wmask));
                end
                REG_BRCTL_ADDR: begin
                    brctl_ff <= 16'(merge({16'h0000, brctl_ff},
                                          avs_writedata, wmask));
                end
                default: begin
                end
            endcase
        end
    end

    // Window registers; fixed low nibbles are never stored
    always_ff @(posedge ref_clk or negedge rst_s2_ff) begin
        if (!rst_s2_ff) begin
            pf_base_ff     <= PF_BASE_RST;
            pf_limit_ff    <= PF_LIMIT_RST;
            pf_base_hi_ff  <= PF_HI_RST;
            pf_limit_hi_ff <= PF_HI_RST;
        end else if (avs_write && ack_ff) begin
            case (avs_address)
                REG_PF_BASE_ADDR: begin
                    pf_base_ff  <= nxt_pf[15:4];
                    pf_limit_ff <= nxt_pf[31:20];
                end
                REG_PF_BHI_ADDR: begin
                    pf_base_hi_ff <= merge(pf_base_hi_ff,
                                           avs_writedata, wmask);
                end
                REG_PF_LHI_ADDR: begin
                    pf_limit_hi_ff <= merge(pf_limit_hi_ff,
                                            avs_writedata, wmask);
                end
                default: begin
                end
            endcase
        end
    end

    always_comb begin
        case (avs_address)
            REG_CMD_ADDR:     rd_mux = {16'h0000, cmd_ff};
            REG_PF_BASE_ADDR: rd_mux = {pf_limit_ff, PF_LOW_NIBBLE,
                                        pf_base_ff, PF_LOW_NIBBLE};
            REG_PF_BHI_ADDR:  rd_mux = pf_base_hi_ff;
            REG_PF_LHI_ADDR:  rd_mux = pf_limit_hi_ff;
            REG_BRCTL_ADDR:   rd_mux = {16'h0000, brctl_ff};
            REG_STATUS_ADDR:  rd_mux = {14'h0000, dly_st_ff, 8'h00,
                                        hit_cnt_ff};
            default:          rd_mux = 32'h0000_0000;
        endcase
    end

    // Acknowledge drops after one cycle; a request still held is taken again two cycles later
    always_ff @(posedge ref_clk or negedge rst_s2_ff) begin
        if (!rst_s2_ff) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= acc;
        end
    end

    // Own flop keeps waitrequest high through reset
    always_ff @(posedge ref_clk or negedge rst_s2_ff) begin
        if (!rst_s2_ff) begin
            wait_ff <= 1'b1;
        end else begin
            wait_ff <= ~acc;
        end
    end

    // Read data is zero outside the acknowledge cycle
    always_ff @(posedge ref_clk or negedge rst_s2_ff) begin
        if (!rst_s2_ff) begin
            rdata_ff <= 32'h0000_0000;
        end else begin
            rdata_ff <= acc ? rd_mux : 32'h0000_0000;
        end
    end

    // Unmapped addresses answer with a decode error
    always_ff @(posedge ref_clk or negedge rst_s2_ff) begin
        if (!rst_s2_ff) begin
            resp_ff <= 2'b00;
        end else begin
            resp_ff <= (acc && avs_address > REG_STATUS_ADDR) ?
                       2'b11 : 2'b00;
        end
    end

    assign avs_readdata    = rdata_ff;
    assign avs_waitrequest = wait_ff;
    assign avs_response    = resp_ff;

    // Window decode
    logic [63:0] pf_lo64;
    logic [63:0] pf_hi64;
    logic [63:0] addr64;
    logic        pf_en;
    logic        pf_hit;
    logic        vga_mode;
    logic        vga_snoop;
    logic        is_mem;
    logic        is_io;
    logic        is_wr;
    logic        is_rd;
    logic        io_low64k;
    logic [9:0]  io_a;
    logic        vga_fb_hit;
    logic        vga_io_hit;
    logic        pal_hit;

    // expand base with zeros, limit with ones
    assign pf_lo64 = {pf_base_hi_ff, pf_base_ff, PF_BASE_FILL};
    assign pf_hi64 = {pf_limit_hi_ff, pf_limit_ff, PF_LIMIT_FILL};
    // SAC compared with upper half zero
    assign addr64  = req_in.dac ? req_in.addr
                                : {32'h0000_0000, req_in.addr[31:0]};
    assign pf_en   = pf_lo64 <= pf_hi64;
    assign pf_hit  = pf_en && addr64 >= pf_lo64 && addr64 <= pf_hi64;

    assign vga_mode  = brctl_ff[BRCTL_VGA_BIT];
    // snoop is moot under VGA mode
    assign vga_snoop = cmd_ff[CMD_VGA_SNOOP_BIT] & ~vga_mode;

    assign is_mem = req_in.cmd inside {CMD_MEM_RD, CMD_MEM_WR, CMD_MEM_RM,
                                       CMD_MEM_RL, CMD_MEM_WI};
    assign is_io  = req_in.cmd inside {CMD_IO_RD, CMD_IO_WR};
    assign is_wr  = req_in.cmd inside {CMD_MEM_WR, CMD_MEM_WI, CMD_IO_WR,
                                       CMD_CFG_WR};
    assign is_rd  = req_in.cmd inside {CMD_MEM_RD, CMD_MEM_RM, CMD_MEM_RL,
                                       CMD_IO_RD, CMD_CFG_RD};

    assign io_low64k = req_in.addr[31:16] == 16'h0000 && !req_in.dac;
    assign io_a      = req_in.addr[9:0];
    assign vga_fb_hit = is_mem && !req_in.dac &&
                        req_in.addr[31:0] >= VGA_FB_LO &&
                        req_in.addr[31:0] <= VGA_FB_HI;
    assign vga_io_hit = is_io && io_low64k &&
                        ((io_a >= VGA_IO_A_LO && io_a <= VGA_IO_A_HI) ||
                         (io_a >= VGA_IO_B_LO && io_a <= VGA_IO_B_HI));
    assign pal_hit = req_in.cmd == CMD_IO_WR && io_low64k &&
                     (io_a == VGA_PAL_MASK || io_a == VGA_PAL_WADDR ||
                      io_a == VGA_PAL_DATA);

    bpvd_dec_t nxt_dec;
    always_comb begin
        logic vga_any;
        logic down;
        logic up;
        nxt_dec = '0;
        vga_any = 1'b0;
        down    = 1'b0;
        up      = 1'b0;
        if (vga_mode && (vga_fb_hit || vga_io_hit)) begin
            vga_any = 1'b1;
        end
        if (!req_in.from_sec) begin
            down = is_mem && pf_hit && cmd_ff[CMD_MEM_EN_BIT] &&
                   (req_in.dac || pf_base_hi_ff == PF_HI_RST);
            if (vga_any && (vga_io_hit || cmd_ff[CMD_MEM_EN_BIT])) begin
                down = 1'b1;
            end
            if (vga_snoop && pal_hit) begin
                down = 1'b1;
            end
        end else begin
            up = (is_mem || is_io) && !pf_hit && !vga_any &&
                 cmd_ff[CMD_MASTER_EN_BIT];
        end
        nxt_dec.fwd_down = req_in.valid && down;
        nxt_dec.fwd_up   = req_in.valid && up;
        nxt_dec.claim    = nxt_dec.fwd_down || nxt_dec.fwd_up;
        nxt_dec.devsel   = nxt_dec.claim;
        // prefetch downstream memory reads in window
        // A frame buffer hit in VGA mode overrides the window
        nxt_dec.prefetch = nxt_dec.fwd_down && is_rd && is_mem &&
                           pf_hit && !(vga_any && vga_fb_hit);
        nxt_dec.single_phase = nxt_dec.fwd_down && is_rd &&
                               vga_any && vga_fb_hit;
        nxt_dec.be_n     = req_in.be_n;
        if (!nxt_dec.claim) begin
            nxt_dec.cls = BPVD_CLS_NONE;
        end else if (req_in.cmd == CMD_MEM_WR ||
                     req_in.cmd == CMD_MEM_WI) begin
            nxt_dec.cls = BPVD_CLS_POSTED;
        end else if (is_wr) begin
            nxt_dec.cls = BPVD_CLS_DLY_WR;
        end else begin
            nxt_dec.cls = BPVD_CLS_DLY_RD;
        end
        nxt_dec.retry = nxt_dec.claim && nxt_dec.cls != BPVD_CLS_POSTED;
    end

    // Result trails req_in by one cycle
    always_ff @(posedge ref_clk or negedge rst_s2_ff) begin
        if (!rst_s2_ff) begin
            dec_ff <= '0;
        end else begin
            dec_ff <= nxt_dec;
        end
    end

    // Claim counter wraps; software reads it as an activity gauge
    always_ff @(posedge ref_clk or negedge rst_s2_ff) begin
        if (!rst_s2_ff) begin
            hit_cnt_ff <= 8'h00;
        end else if (nxt_dec.claim) begin
            hit_cnt_ff <= hit_cnt_ff + 8'h01;
        end
    end

    assign dec_out = dec_ff;

    // delayed write response held then returned
    always_ff @(posedge ref_clk or negedge rst_s2_ff) begin
        if (!rst_s2_ff) begin
            dly_st_ff   <= BPVD_ST_IDLE;
            dly_resp_ff <= 2'b00;
            dly_vld_ff  <= 1'b0;
        end else begin
            dly_vld_ff <= 1'b0;
            case (dly_st_ff)
                BPVD_ST_IDLE: begin
                    if (nxt_dec.cls == BPVD_CLS_DLY_WR) begin
                        dly_st_ff <= BPVD_ST_WAIT;
                    end
                end
                BPVD_ST_WAIT: begin
                    if (tgt_done) begin
                        dly_resp_ff <= tgt_resp;
                        dly_st_ff   <= BPVD_ST_DONE;
                    end
                end
                BPVD_ST_DONE: begin
                    dly_vld_ff <= 1'b1;
                    dly_st_ff  <= BPVD_ST_IDLE;
                end
                default: begin
                    dly_st_ff <= BPVD_ST_IDLE;
                end
            endcase
        end
    end

    assign dly_wr_resp_valid = dly_vld_ff;
    assign dly_wr_resp       = dly_resp_ff;

endmodule : bpvd_bridge_decode

// ==== hw/bpvd_pkg.sv ====
package bpvd_pkg;

    // Register word addresses on the Avalon-MM slave
    localparam logic [3:0]  REG_CMD_ADDR      = 4'h0;
    localparam logic [3:0]  REG_PF_BASE_ADDR  = 4'h1;
    localparam logic [3:0]  REG_PF_BHI_ADDR   = 4'h2;
    localparam logic [3:0]  REG_PF_LHI_ADDR   = 4'h3;
    localparam logic [3:0]  REG_BRCTL_ADDR    = 4'h4;
    localparam logic [3:0]  REG_STATUS_ADDR   = 4'h5;
    localparam logic [7:0]  PF_BASE_OFS       = 8'h24;
    localparam logic [7:0]  PF_LIMIT_OFS      = 8'h26;

    // Command register bits
    localparam int CMD_MEM_EN_BIT    = 1;
    localparam int CMD_MASTER_EN_BIT = 2;
    localparam int CMD_VGA_SNOOP_BIT = 5;
    // Bridge control bit
    localparam int BRCTL_VGA_BIT     = 3;

    // Prefetch window field layout and reset values
    localparam logic [3:0]  PF_LOW_NIBBLE    = 4'h1;
    localparam logic [11:0] PF_BASE_RST      = 12'h000;
    localparam logic [11:0] PF_LIMIT_RST     = 12'h000;
    localparam logic [31:0] PF_HI_RST        = 32'h0000_0000;
    localparam logic [19:0] PF_BASE_FILL     = 20'h0_0000;
    localparam logic [19:0] PF_LIMIT_FILL    = 20'hF_FFFF;

    // VGA decode ranges
    localparam logic [31:0] VGA_FB_LO        = 32'h000A_0000;
    localparam logic [31:0] VGA_FB_HI        = 32'h000B_FFFF;
    localparam logic [9:0]  VGA_IO_A_LO      = 10'h3B0;
    localparam logic [9:0]  VGA_IO_A_HI      = 10'h3BB;
    localparam logic [9:0]  VGA_IO_B_LO      = 10'h3C0;
    localparam logic [9:0]  VGA_IO_B_HI      = 10'h3DF;
    localparam logic [9:0]  VGA_PAL_MASK     = 10'h3C6;
    localparam logic [9:0]  VGA_PAL_WADDR    = 10'h3C8;
    localparam logic [9:0]  VGA_PAL_DATA     = 10'h3C9;

    // Bus command codes
    localparam logic [3:0] CMD_IO_RD   = 4'h2;
    localparam logic [3:0] CMD_IO_WR   = 4'h3;
    localparam logic [3:0] CMD_MEM_RD  = 4'h6;
    localparam logic [3:0] CMD_MEM_WR  = 4'h7;
    localparam logic [3:0] CMD_CFG_RD  = 4'hA;
    localparam logic [3:0] CMD_CFG_WR  = 4'hB;
    localparam logic [3:0] CMD_MEM_RM  = 4'hC;
    localparam logic [3:0] CMD_MEM_RL  = 4'hE;
    localparam logic [3:0] CMD_MEM_WI  = 4'hF;

    typedef enum logic [1:0] {
        BPVD_CLS_NONE    = 2'b00,
        BPVD_CLS_POSTED  = 2'b01,
        BPVD_CLS_DLY_WR  = 2'b11,
        BPVD_CLS_DLY_RD  = 2'b10
    } bpvd_class_t;

    typedef enum logic [1:0] {
        BPVD_ST_IDLE = 2'b00,
        BPVD_ST_WAIT = 2'b01,
        BPVD_ST_DONE = 2'b11
    } bpvd_dly_st_t;

    // Transaction presented for decode
    typedef struct packed {
        logic        valid;
        logic        from_sec;
        logic [3:0]  cmd;
        logic        dac;
        logic [63:0] addr;
        logic [3:0]  be_n;
    } bpvd_req_t;

    // Decode result
    typedef struct packed {
        logic        claim;
        logic        fwd_down;
        logic        fwd_up;
        logic        prefetch;
        logic        single_phase;
        logic        retry;
        bpvd_class_t cls;
        logic [3:0]  be_n;
        logic        devsel;
    } bpvd_dec_t;

endpackage : bpvd_pkg

// ==== testbench/bpvd_bridge_decode_assertions.sv ====
`timescale 1ns/1ps
module bpvd_checker (
    input wire logic                ref_clk,
    input wire logic                reset_n,
    input wire logic                avs_read,
    input wire logic                avs_write,
    input wire logic                avs_waitrequest,
    input wire bpvd_pkg::bpvd_req_t req_in,
    input wire logic                tgt_done,
    input wire bpvd_pkg::bpvd_dec_t dec_out,
    input wire logic                dly_wr_resp_valid
);
    import bpvd_pkg::*;
    logic rd_cmd;
    logic wr_mem;
    assign rd_cmd = req_in.valid && req_in.cmd inside {CMD_IO_RD, CMD_MEM_RD,
                    CMD_MEM_RM, CMD_MEM_RL};
    assign wr_mem = req_in.valid && req_in.cmd inside {CMD_MEM_WR, CMD_MEM_WI};
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    a_ack_one_cycle: assert property (
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("register access not acknowledged after one cycle");
    a_be_pass: assert property (
        req_in.valid |=> dec_out.be_n == $past(req_in.be_n))
        else $error("byte enables changed");
    a_sec_no_down: assert property (
        req_in.valid && req_in.from_sec |=> !dec_out.fwd_down)
        else $error("secondary request sent downstream");
    a_pri_no_up: assert property (
        req_in.valid && !req_in.from_sec |=> !dec_out.fwd_up)
        else $error("primary request sent upstream");
    a_write_posted: assert property (
        wr_mem ##1 (dec_out.fwd_down || dec_out.fwd_up) |->
        dec_out.cls == BPVD_CLS_POSTED && !dec_out.retry)
        else $error("memory write not posted");
    a_read_retried: assert property (
        rd_cmd ##1 (dec_out.fwd_down || dec_out.fwd_up) |->
        dec_out.retry && dec_out.cls == BPVD_CLS_DLY_RD)
        else $error("read not retried as delayed");
    a_io_wr_delay: assert property (
        req_in.valid && req_in.cmd == CMD_IO_WR ##1 dec_out.fwd_down |->
        dec_out.retry && dec_out.cls == BPVD_CLS_DLY_WR)
        else $error("io write not delayed");
    a_write_no_pref: assert property (
        wr_mem |=> !dec_out.prefetch && !dec_out.single_phase)
        else $error("write marked as read");
    a_fwd_claims: assert property (
        dec_out.fwd_down |-> dec_out.claim && dec_out.devsel)
        else $error("forwarded without claim");
    a_resp_pulse: assert property (
        dly_wr_resp_valid |=> !dly_wr_resp_valid)
        else $error("response pulse too long");
    a_resp_cause: assert property (
        $rose(dly_wr_resp_valid) |->
        $past(tgt_done, 1) || $past(tgt_done, 2) || $past(tgt_done, 3))
        else $error("response without target completion");
    c_prefetch: cover property (dec_out.fwd_down && dec_out.prefetch);
    c_single: cover property (dec_out.fwd_down && dec_out.single_phase);
    c_upstream: cover property (dec_out.fwd_up);
    c_resp: cover property (dly_wr_resp_valid);
endmodule : bpvd_checker

bind bpvd_bridge_decode bpvd_checker bpvd_checker_inst (.ref_clk, .reset_n,
    .avs_read, .avs_write, .avs_waitrequest, .req_in, .tgt_done, .dec_out,
    .dly_wr_resp_valid);

// ==== testbench/bpvd_target_model.sv ====
`timescale 1ns/1ps
module bpvd_target_model (
    input  wire logic       ref_clk,
    input  wire logic       reset_n,
    input  wire logic       arm,
    input  wire logic [1:0] resp_code,
    input  wire logic [3:0] delay,
    output logic            tgt_done,
    output logic [1:0]      tgt_resp
);
    logic       busy_ff;
    logic [3:0] cnt_ff;
    // target finishes the write later, gives its code
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            busy_ff  <= 1'b0;
            cnt_ff   <= 4'h0;
            tgt_done <= 1'b0;
            tgt_resp <= 2'h0;
        end else begin
            tgt_done <= busy_ff && cnt_ff == 4'h0;
            // Code only meaningful with done; otherwise it toggles
            tgt_resp <= (busy_ff && cnt_ff == 4'h0) ? resp_code : ~tgt_resp;
            if (!busy_ff && arm) begin
                busy_ff <= 1'b1;
                cnt_ff  <= delay;
            end else if (busy_ff && cnt_ff == 4'h0) begin
                busy_ff <= 1'b0;
            end else if (busy_ff) begin
                cnt_ff <= cnt_ff - 4'h1;
            end
        end
    end
endmodule : bpvd_target_model

// ==== testbench/bridge_prefetch_vga_decode_test.sv ====
`timescale 1ns/1ps
module bridge_prefetch_vga_decode_test;
    import bpvd_pkg::*;
    logic        ref_clk, reset_n, avs_read, avs_write, avs_waitrequest;
    logic [3:0]  avs_address, avs_byteenable, delay;
    logic [31:0] avs_writedata, avs_readdata, bh, lh, q;
    logic [1:0]  avs_response, tgt_resp, dly_wr_resp, resp_code, rs;
    logic        tgt_done, dly_wr_resp_valid, mem_en, mst_en, snoop, vga;
    logic [11:0] pb, pl;
    bpvd_req_t   req_in;
    bpvd_dec_t   dec_out;
    int          bad_count, tests_run, n;

    bpvd_bridge_decode bpvd_bridge_decode_inst (.ref_clk, .reset_n,
        .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
        .avs_readdata, .avs_waitrequest, .avs_response, .req_in, .tgt_done,
        .tgt_resp, .dec_out, .dly_wr_resp_valid, .dly_wr_resp);
    bpvd_target_model bpvd_target_model_inst (.ref_clk, .reset_n,
        .arm(dec_out.claim && dec_out.cls == BPVD_CLS_DLY_WR), .resp_code,
        .delay, .tgt_done, .tgt_resp);

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    task stop_test();
        if (bad_count == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : stop_test

    task check(input string nm, input logic [31:0] seen, input logic [31:0] e);
        tests_run++;
        if (seen !== e) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, e, seen);
        end
    endtask : check

    task av(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int k;
        @(posedge ref_clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= !wr;
        k = 0;
        do begin
            @(posedge ref_clk);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 20);
        if (k >= 20) begin
            bad_count++;
            stop_test();
        end
        q = avs_readdata;
        rs = avs_response;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask : av

    task setup(input logic [11:0] b, input logic [11:0] l,
               input logic [31:0] h0, input logic [31:0] h1,
               input logic [3:0] f);
        logic [31:0] w;
        {vga, snoop, mst_en, mem_en} = f;
        pb = b;
        pl = l;
        bh = h0;
        lh = h1;
        w = 32'h0;
        w[CMD_MEM_EN_BIT] = mem_en;
        w[CMD_MASTER_EN_BIT] = mst_en;
        w[CMD_VGA_SNOOP_BIT] = snoop;
        av(1'b1, REG_PF_BASE_ADDR, {l, 4'h0, b, 4'h0});
        av(1'b1, REG_PF_BHI_ADDR, h0);
        av(1'b1, REG_PF_LHI_ADDR, h1);
        av(1'b1, REG_CMD_ADDR, w);
        av(1'b1, REG_BRCTL_ADDR, 32'(vga) << BRCTL_VGA_BIT);
        av(1'b0, REG_PF_BASE_ADDR, 32'h0);
        check("window", q, {l, 4'h1, b, 4'h1});
        av(1'b0, REG_PF_LHI_ADDR, 32'h0);
        check("limit_high", q, h1);
    endtask : setup

    function automatic logic [9:0] expect_dec(bpvd_req_t r);
        logic [63:0] a;
        logic        mem, rd, io, win, fb, hz, vio, pal, fd, fu;
        bpvd_class_t c;
        a = r.dac ? r.addr : {32'h0, r.addr[31:0]};
        mem = r.cmd inside {CMD_MEM_RD, CMD_MEM_WR, CMD_MEM_RM, CMD_MEM_RL,
                            CMD_MEM_WI};
        rd = r.cmd inside {CMD_IO_RD, CMD_MEM_RD, CMD_MEM_RM, CMD_MEM_RL};
        io = r.cmd inside {CMD_IO_RD, CMD_IO_WR};
        win = a >= {bh, pb, PF_BASE_FILL} && a <= {lh, pl, PF_LIMIT_FILL};
        fb = vga && !r.dac && a[31:0] >= VGA_FB_LO && a[31:0] <= VGA_FB_HI;
        hz = !r.dac && a[31:16] == 16'h0;
        vio = vga && hz && a[9:0] inside {[VGA_IO_A_LO:VGA_IO_A_HI],
                                          [VGA_IO_B_LO:VGA_IO_B_HI]};
        pal = snoop && hz && r.cmd == CMD_IO_WR &&
              a[9:0] inside {VGA_PAL_MASK, VGA_PAL_WADDR, VGA_PAL_DATA};
        fd = !r.from_sec && (mem && mem_en && (win || fb) || io && (vio || pal));
        fu = r.from_sec && mem && mst_en && !win && !fb;
        c = !(fd || fu) ? BPVD_CLS_NONE : rd ? BPVD_CLS_DLY_RD :
            io ? BPVD_CLS_DLY_WR : BPVD_CLS_POSTED;
        return {fd, fu, fd && mem && rd && win && !fb, fd && mem && rd && fb,
                c, r.be_n};
    endfunction : expect_dec

    function automatic bpvd_req_t rnd_req();
        bpvd_req_t  r;
        logic [3:0] tbl [9] = '{CMD_IO_RD, CMD_IO_WR, CMD_MEM_RD, CMD_MEM_WR,
                                CMD_MEM_RM, CMD_MEM_RL, CMD_MEM_WI,
                                CMD_CFG_RD, CMD_CFG_WR};
        r.valid = $urandom_range(7) != 0;
        r.from_sec = $urandom_range(3) == 0;
        r.cmd = tbl[r.from_sec ? $urandom_range(8, 2) : $urandom_range(8, 0)];
        r.dac = $urandom_range(3) == 0;
        r.be_n = 4'($urandom);
        case ($urandom_range(4))
            0: r.addr = {r.dac ? bh : 32'h0, pb, 20'h0} - 64'($urandom_range(1));
            1: r.addr = {r.dac ? lh : 32'h0, pl, 20'hFFFFF}
                        + 64'($urandom_range(1));
            2: r.addr = 64'(VGA_FB_LO) + 64'($urandom_range(32'h20000))
                        - 64'($urandom_range(1));
            3: r.addr = {46'h0, 2'($urandom_range(1)), 6'($urandom),
                         10'($urandom_range(10'h3E0, 10'h3AF))};
            default: r.addr = {$urandom, $urandom};
        endcase
        if (!r.dac) r.addr[63:32] = $urandom;
        return r;
    endfunction : rnd_req

    task run(input int cnt);
        bpvd_req_t p1;
        bpvd_req_t p2;
        p1 = '0;
        p2 = '0;
        for (int i = 0; i < cnt + 2; i++) begin
            @(posedge ref_clk);
            if (p2.valid) check("decode", 32'({dec_out.fwd_down, dec_out.fwd_up,
                dec_out.prefetch, dec_out.single_phase, dec_out.cls,
                dec_out.be_n}),
                32'(expect_dec(p2)));
            p2 = p1;
            p1 = (i < cnt) ? rnd_req() : '0;
            req_in <= p1;
        end
    endtask : run

    initial begin
        {avs_address, avs_read, avs_write, avs_writedata} = '0;
        avs_byteenable = 4'hF;
        req_in = '0;
        reset_n = 1'b0;
        resp_code = 2'h2;
        delay = 4'h0;
        bad_count = 0;
        tests_run = 0;
        void'($urandom(32'h6EDF));
        repeat (12) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        av(1'b0, REG_PF_BASE_ADDR, 32'h0);
        check("window_reset", q, 32'h0001_0001);
        av(1'b0, REG_PF_BHI_ADDR, 32'h0);
        check("base_high_reset", q, 32'h0);
        av(1'b0, 4'hF, 32'h0);
        check("unmapped", {q[29:0], rs}, 32'h3);
        for (int c = 0; c < 6; c++) begin
            case (c)
                0: setup(12'h100, 12'h1FF, 32'h0, 32'h0, 4'b0111);
                1: setup(12'h100, 12'h1FF, 32'h0, 32'h0, 4'b1111);
                2: setup(12'h200, 12'h1FF, 32'h5, 32'h5, 4'b1011);
                3: setup(12'h300, 12'h100, 32'h1, 32'h2, 4'b0011);
                4: setup(12'h000, 12'h0FF, 32'h0, 32'h0, 4'b0011);
                default: setup(12'h000, 12'h0FF, 32'h0, 32'h0, 4'b1000);
            endcase
            run(300);
        end
        setup(12'h100, 12'h1FF, 32'h0, 32'h0, 4'b0111);
        delay <= 4'hC;
        resp_code <= 2'h1;
        repeat (40) @(posedge ref_clk);
        req_in <= '{valid: 1'b1, from_sec: 1'b0, cmd: CMD_IO_WR, dac: 1'b0,
                    addr: 64'h7C9, be_n: 4'h0};
        @(posedge ref_clk);
        req_in <= '0;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (dly_wr_resp_valid !== 1'b1 && n < 60);
        check("dly_resp", {n < 60, dly_wr_resp}, {1'b1, resp_code});
        check("dly_order", 32'(n > 12), 32'h1);
        stop_test();
    end
endmodule : bridge_prefetch_vga_decode_test
